// ===== design/rx_pause_flow_control.sv
// Receive pause flow control: frame check, pause timers, transmit stop, forwarding and APB registers
//
// What this block does
// - Pause candidate needs control multicast or station address zero as destination
// - Candidate type field must equal the MAC control ethertype
// - Candidate opcode must equal the pause opcode
// - Non-zero pause time is XOFF, zero is XON cancelling a pause
// - Pause time counts quanta of 64 byte times at line speed
// - Priority frames match the programmed priority type and opcode
// - Eight priority timers map through the receive binding table to classes
// - Classes shared by priorities pause for the largest timer
// - Formatted priority frames copy timer and enable to all bound priorities
// - Off-mode pause frames are ignored and count nothing
// - Validated XOFF counts and reloads timers, priority classes take maximum
// - Validated XOFF stops new transmissions, per class in priority mode
// - Manageability traffic pauses with its mapped class
// - Timer expiry or XON resumes and clears transmit-off status
// - Accepted XON frames are counted
// - At 10G stop within 74 quanta of a link XOFF
// - At 1G stop within two quanta of a link XOFF
// - Discard bit governs forwarding of pause frames, L2 filters still apply
// - Pass bit governs other control frames, including pause frames of disabled modes
// - With virtualization on, forwarded control frames go through the switch
// - Without DCB only index zero of per-class state is used
//
// The APB slave port and the placing of the registers are this design's own decisions.
module rx_pause_flow_control
	import rx_pause_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	input  wire rx_pause_pkg::apb_req_s apb_req,
	output      rx_pause_pkg::apb_rsp_s apb_rsp,
	input  wire rx_pause_pkg::rx_byte_s rx,
	output      rx_pause_pkg::fwd_s     fwd,
	input  wire rx_pause_pkg::fmt_req_s fmt_req,
	output      rx_pause_pkg::fmt_out_s fmt_out,
	output      logic [7:0]             tx_class_pause,
	output      logic                   mng_tx_pause
);
	typedef struct packed {
		apb_req_s         unused_pad;
		apb_rsp_s         rsp;
		logic [31:0]      mac_flow_ctrl_register;
		logic [31:0]      priority_pause_type_opcode;
		logic [23:0]      rx_pause_priority_to_tx_class_map;
		logic [23:0]      tx_pause_priority_to_rx_class_map;
		logic [2:0]       manageability_tx_class_map;
		logic [2:0]       rx_ctrl;
		logic [31:0]      station_lo;
		logic [15:0]      station_hi;
		logic [1:0]       speed;
		logic [31:0]      xon_count;
		logic [31:0]      xoff_count;
		logic [5:0]       pos;
		logic [47:0]      dest;
		logic [15:0]      frame_type;
		logic [15:0]      opcode;
		logic [15:0]      field;
		logic [7:0][15:0] up_timer;
		logic [19:0]      quantum_acc;
		logic [7:0][15:0] pause_timer;
		logic [7:0]       tx_paused_flag;
		logic [7:0]       tx_pause;
		logic             mng_pause;
		fwd_s             fwd;
		fmt_out_s         fmt;
	} state_s;

	state_s s;
	state_s n;

	function automatic logic [2:0] class_of(input logic [23:0] map, input int unsigned up);
		class_of = map[up*CLASS_W +: CLASS_W];
	endfunction

	function automatic logic [19:0] quantum_ps(input logic [1:0] speed);
		case (speed)
			SPEED_2G5: quantum_ps = QUANTUM_PS_2G5;
			SPEED_1G:  quantum_ps = QUANTUM_PS_1G;
			default:   quantum_ps = QUANTUM_PS_10G;
		endcase
	endfunction

	logic             link_mode;
	logic             pfc_mode;
	logic             dest_ok;
	logic             is_ctrl;
	logic             link_hit;
	logic             pfc_hit;
	logic             link_act;
	logic             pfc_act;
	logic [47:0]      station;
	logic [7:0]       up_en;
	logic [7:0]       class_hit;
	logic [7:0][15:0] class_max;
	logic             any_xoff;
	logic             tick;
	logic [2:0]       cls;
	logic [31:0]      rd;
	logic             hit;
	logic [3:0]       tslot;

	assign apb_rsp        = s.rsp;
	assign fwd            = s.fwd;
	assign fmt_out        = s.fmt;
	assign tx_class_pause = s.tx_pause;
	assign mng_tx_pause   = s.mng_pause;

	always_comb begin
		n         = s;
		rd        = 32'h0000_0000;
		hit       = 1'b1;
		class_hit = 8'h00;
		class_max = '0;
		any_xoff  = 1'b0;
		tick      = 1'b0;
		cls       = 3'h0;
		tslot     = 4'h0;
		n.unused_pad = '0;
		n.fwd.valid  = 1'b0;
		n.fmt.valid  = 1'b0;
		up_en     = s.mac_flow_ctrl_register[FC_UP_EN_LSB +: 8];
		// Link mode wins only when priority mode is off; both set is a software fault
		pfc_mode  = s.mac_flow_ctrl_register[FC_GLOBAL_BIT] & s.mac_flow_ctrl_register[FC_DCB_EN_BIT];
		link_mode = s.mac_flow_ctrl_register[FC_LINK_EN_BIT] & ~pfc_mode;
		station   = {s.station_lo[7:0], s.station_lo[15:8], s.station_lo[23:16], s.station_lo[31:24],
		             s.station_hi[7:0], s.station_hi[15:8]};

		// Register read decode
		case (apb_req.paddr)
			OFF_FLOW_CTRL:     rd = s.mac_flow_ctrl_register;
			OFF_TYPE_OPCODE:   rd = s.priority_pause_type_opcode;
			OFF_RX_CLASS_MAP:  rd = {8'h00, s.rx_pause_priority_to_tx_class_map};
			OFF_TX_CLASS_MAP:  rd = {8'h00, s.tx_pause_priority_to_rx_class_map};
			OFF_MNG_CLASS_MAP: rd = {29'h0, s.manageability_tx_class_map};
			OFF_RX_CTRL:       rd = {29'h0, s.rx_ctrl};
			OFF_STATION_LO:    rd = s.station_lo;
			OFF_STATION_HI:    rd = {16'h0000, s.station_hi};
			OFF_SPEED:         rd = {30'h0, s.speed};
			OFF_TX_FC_STATUS:  rd = {24'h000000, s.tx_paused_flag};
			OFF_XON_COUNT:     rd = s.xon_count;
			OFF_XOFF_COUNT:    rd = s.xoff_count;
			default:           hit = 1'b0;
		endcase

		// APB: setup cycle prepares the answer, access phase completes with one wait-free cycle
		n.rsp.pready  = 1'b0;
		n.rsp.pslverr = 1'b0;
		if (apb_req.psel && !apb_req.penable) begin
			n.rsp.pready  = 1'b1;
			n.rsp.pslverr = ~hit;
			n.rsp.prdata  = hit ? rd : 32'h0000_0000;
		end
		if (apb_req.psel && apb_req.penable && s.rsp.pready && apb_req.pwrite) begin
			case (apb_req.paddr)
				OFF_FLOW_CTRL:     n.mac_flow_ctrl_register = apb_req.pwdata;
				OFF_TYPE_OPCODE:   n.priority_pause_type_opcode = apb_req.pwdata;
				OFF_RX_CLASS_MAP:  n.rx_pause_priority_to_tx_class_map = apb_req.pwdata[23:0];
				OFF_TX_CLASS_MAP:  n.tx_pause_priority_to_rx_class_map = apb_req.pwdata[23:0];
				OFF_MNG_CLASS_MAP: n.manageability_tx_class_map = apb_req.pwdata[2:0];
				OFF_RX_CTRL:       n.rx_ctrl = apb_req.pwdata[2:0];
				OFF_STATION_LO:    n.station_lo = apb_req.pwdata;
				OFF_STATION_HI:    n.station_hi = apb_req.pwdata[15:0];
				OFF_SPEED:         n.speed = apb_req.pwdata[1:0];
				default:           n.speed = s.speed;
			endcase
		end

		// Quantum clock: picosecond accumulator keeps 10G quanta exact though not whole cycles
		if (s.quantum_acc + CLOCK_STEP_PS >= quantum_ps(s.speed)) begin
			n.quantum_acc = s.quantum_acc + CLOCK_STEP_PS - quantum_ps(s.speed);
			tick          = 1'b1;
		end else begin
			n.quantum_acc = s.quantum_acc + CLOCK_STEP_PS;
		end
		for (int c = 0; c < 8; c++) begin
			if (tick && s.pause_timer[c] != 16'h0000) begin
				n.pause_timer[c] = s.pause_timer[c] - 16'h0001;
				if (s.pause_timer[c] == 16'h0001) begin
					n.tx_paused_flag[c] = 1'b0;
				end
			end
		end

		// Frame field capture by byte position
		if (rx.valid) begin
			if (s.pos < POS_DA_END) begin
				n.dest = {s.dest[39:0], rx.data};
			end
			case (s.pos)
				POS_TYPE:             n.frame_type[15:8] = rx.data;
				POS_TYPE + 6'h01:     n.frame_type[7:0] = rx.data;
				POS_OPCODE:           n.opcode[15:8] = rx.data;
				POS_OPCODE + 6'h01:   n.opcode[7:0] = rx.data;
				POS_FIELD:            n.field[15:8] = rx.data;
				POS_FIELD + 6'h01:    n.field[7:0] = rx.data;
				default:        n.pos = s.pos;
			endcase
			if (s.pos >= POS_TIMERS && s.pos <= POS_TIMERS_END) begin
				tslot = 4'(s.pos - POS_TIMERS);
				if (tslot[0]) begin
					n.up_timer[tslot[3:1]][7:0] = rx.data;
				end else begin
					n.up_timer[tslot[3:1]][15:8] = rx.data;
				end
			end
			n.pos = (s.pos == POS_MAX) ? s.pos : s.pos + 6'h01;
		end

		dest_ok  = (s.dest == CTRL_MCAST_ADDR) || (s.dest == station);
		is_ctrl  = s.frame_type == MAC_CTRL_TYPE;
		link_hit = dest_ok && is_ctrl && s.opcode == PAUSE_OPCODE;
		pfc_hit  = dest_ok && s.frame_type == s.priority_pause_type_opcode[31:16]
		           && s.opcode == s.priority_pause_type_opcode[15:0] && !link_hit;
		// Nothing happens before the last byte and a good check sequence
		link_act = rx.valid && rx.last && rx.fcs_ok && link_hit && link_mode;
		pfc_act  = rx.valid && rx.last && rx.fcs_ok && pfc_hit && pfc_mode;

		if (link_act) begin
			n.pause_timer[0]    = s.field;
			n.tx_paused_flag[0] = s.field != 16'h0000;
			if (s.field != 16'h0000) begin
				n.xoff_count = s.xoff_count + 32'h1;
			end else begin
				n.xon_count = s.xon_count + 32'h1;
			end
		end

		if (pfc_act) begin
			for (int up = 0; up < 8; up++) begin
				if (s.field[up] && up_en[up]) begin
					cls            = class_of(s.rx_pause_priority_to_tx_class_map, up);
					class_hit[cls] = 1'b1;
					if (s.up_timer[up] > class_max[cls]) begin
						class_max[cls] = s.up_timer[up];
					end
					any_xoff = any_xoff | (s.up_timer[up] != 16'h0000);
				end
			end
			for (int c = 0; c < 8; c++) begin
				if (class_hit[c]) begin
					n.pause_timer[c]    = class_max[c];
					n.tx_paused_flag[c] = class_max[c] != 16'h0000;
				end
			end
			if (class_hit != 8'h00 && any_xoff) begin
				n.xoff_count = s.xoff_count + 32'h1;
			end else if (class_hit != 8'h00) begin
				n.xon_count = s.xon_count + 32'h1;
			end
		end

		// Forwarding decision, one per frame end
		if (rx.valid && rx.last) begin
			n.pos            = 6'h00;
			n.fwd.valid      = 1'b1;
			n.fwd.via_switch = s.rx_ctrl[RC_VIRT_BIT];
			if ((link_hit && link_mode) || (pfc_hit && pfc_mode)) begin
				n.fwd.to_host = rx.fcs_ok && rx.l2_pass && !s.rx_ctrl[RC_DISCARD_BIT];
			end else if (is_ctrl || pfc_hit) begin
				n.fwd.to_host = rx.fcs_ok && rx.l2_pass && s.rx_ctrl[RC_PASS_CTRL_BIT];
			end else begin
				n.fwd.to_host = rx.fcs_ok && rx.l2_pass;
			end
		end

		// Transmit gating: the scheduler finishes the frame in flight, well inside two quanta
		if (link_mode) begin
			n.tx_pause = {8{n.tx_paused_flag[0]}};
		end else if (pfc_mode) begin
			n.tx_pause = n.tx_paused_flag;
		end else begin
			n.tx_pause = 8'h00;
		end
		n.mng_pause = n.tx_pause[s.manageability_tx_class_map];

		// Outgoing priority frame fields
		if (fmt_req.req) begin
			n.fmt.valid = 1'b1;
			for (int up = 0; up < 8; up++) begin
				if (class_of(s.tx_pause_priority_to_rx_class_map, up) == fmt_req.rx_class) begin
					n.fmt.enable_vec[up] = fmt_req.enable;
					n.fmt.timers[up]     = fmt_req.timer;
				end else begin
					n.fmt.enable_vec[up] = 1'b0;
					n.fmt.timers[up]     = 16'h0000;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule

// ===== design/rx_pause_pkg.sv
// Constants and carrier types for the receive pause flow control block
package rx_pause_pkg;
	// APB register map (byte addresses)
	localparam int unsigned  ADDR_W            = 8;
	localparam logic [7:0]   OFF_FLOW_CTRL     = 8'h00;
	localparam logic [7:0]   OFF_TYPE_OPCODE   = 8'h04;
	localparam logic [7:0]   OFF_RX_CLASS_MAP  = 8'h08;
	localparam logic [7:0]   OFF_TX_CLASS_MAP  = 8'h0c;
	localparam logic [7:0]   OFF_MNG_CLASS_MAP = 8'h10;
	localparam logic [7:0]   OFF_RX_CTRL       = 8'h14;
	localparam logic [7:0]   OFF_STATION_LO    = 8'h18;
	localparam logic [7:0]   OFF_STATION_HI    = 8'h1c;
	localparam logic [7:0]   OFF_SPEED         = 8'h20;
	localparam logic [7:0]   OFF_TX_FC_STATUS  = 8'h24;
	localparam logic [7:0]   OFF_XON_COUNT     = 8'h28;
	localparam logic [7:0]   OFF_XOFF_COUNT    = 8'h2c;
	// Field positions
	localparam int unsigned  FC_LINK_EN_BIT    = 0;
	localparam int unsigned  FC_GLOBAL_BIT     = 1;
	localparam int unsigned  FC_DCB_EN_BIT     = 2;
	localparam int unsigned  FC_UP_EN_LSB      = 8;
	localparam int unsigned  RC_DISCARD_BIT    = 0;
	localparam int unsigned  RC_PASS_CTRL_BIT  = 1;
	localparam int unsigned  RC_VIRT_BIT       = 2;
	localparam int unsigned  CLASS_W           = 3;
	// Reset value of every register and counter
	localparam logic [31:0]  REG_RESET         = 32'h0000_0000;
	// Frame recognition
	localparam logic [47:0]  CTRL_MCAST_ADDR   = 48'h0180_c200_0001;
	localparam logic [15:0]  MAC_CTRL_TYPE     = 16'h8808;
	localparam logic [15:0]  PAUSE_OPCODE      = 16'h0001;
	localparam logic [5:0]   POS_TYPE          = 6'h0c;
	localparam logic [5:0]   POS_OPCODE        = 6'h0e;
	localparam logic [5:0]   POS_FIELD         = 6'h10;
	localparam logic [5:0]   POS_TIMERS        = 6'h12;
	localparam logic [5:0]   POS_TIMERS_END    = 6'h21;
	localparam logic [5:0]   POS_DA_END        = 6'h06;
	localparam logic [5:0]   POS_MAX           = 6'h3f;
	// Timing: one pause quantum is 512 bit times
	localparam int unsigned  CLOCK_PERIOD_PS   = 4000;
	localparam int unsigned  QUANTUM_BITS      = 512;
	localparam int unsigned  BIT_PS_10G        = 100;
	localparam int unsigned  BIT_PS_2G5        = 400;
	localparam int unsigned  BIT_PS_1G         = 1000;
	localparam logic [19:0]  CLOCK_STEP_PS     = 20'(CLOCK_PERIOD_PS);
	localparam logic [19:0]  QUANTUM_PS_10G    = 20'(QUANTUM_BITS * BIT_PS_10G);
	localparam logic [19:0]  QUANTUM_PS_2G5    = 20'(QUANTUM_BITS * BIT_PS_2G5);
	localparam logic [19:0]  QUANTUM_PS_1G     = 20'(QUANTUM_BITS * BIT_PS_1G);

	typedef enum logic [1:0] {
		SPEED_10G = 2'b00,
		SPEED_2G5 = 2'b01,
		SPEED_1G  = 2'b10
	} speed_e;

	typedef struct packed {
		logic             psel;
		logic             penable;
		logic             pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]      pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
		logic       fcs_ok;
		logic       l2_pass;
	} rx_byte_s;

	typedef struct packed {
		logic valid;
		logic to_host;
		logic via_switch;
	} fwd_s;

	typedef struct packed {
		logic              req;
		logic [CLASS_W-1:0] rx_class;
		logic              enable;
		logic [15:0]       timer;
	} fmt_req_s;

	typedef struct packed {
		logic             valid;
		logic [7:0]       enable_vec;
		logic [7:0][15:0] timers;
	} fmt_out_s;
endpackage

// ===== verification/link_partner_model.sv
// Remote link partner: streams one 64-byte frame into the receive port
module link_partner_model
	import rx_pause_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   start,
	input  wire logic [0:63][7:0]       frame,
	input  wire logic                   good,
	output      rx_pause_pkg::rx_byte_s rx
);
	timeunit 1ns;
	timeprecision 1ps;
	int idx = 0;
	initial rx = '0;
	// Idle data toggles so a stale byte never looks valid
	always @(posedge clock) begin
		if (start || idx != 0) begin
			rx.valid   <= 1'b1;
			rx.data    <= frame[idx];
			rx.last    <= idx == 63;
			rx.fcs_ok  <= (idx == 63) ? good : ~good;
			rx.l2_pass <= idx == 63;
			idx        <= (idx + 1) % 64;
		end else begin
			rx.valid <= 1'b0;
			rx.last  <= 1'b0;
			rx.data  <= ~rx.data;
		end
	end
endmodule

// ===== verification/rx_pause_asserts.sv
// Checker for the receive pause flow control ports
module rx_pause_asserts
	import rx_pause_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	input  wire rx_pause_pkg::apb_req_s apb_req,
	input  wire rx_pause_pkg::apb_rsp_s apb_rsp,
	input  wire rx_pause_pkg::rx_byte_s rx,
	input  wire rx_pause_pkg::fwd_s     fwd,
	input  wire rx_pause_pkg::fmt_req_s fmt_req,
	input  wire rx_pause_pkg::fmt_out_s fmt_out,
	input  wire logic [7:0]             tx_class_pause,
	input  wire logic                   mng_tx_pause
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire eof = rx.valid && rx.last;
	fwd_timing_a: assert property (eof |=> fwd.valid)
		else $error("no forward decision after frame end");
	fwd_cause_a: assert property (fwd.valid |-> $past(eof))
		else $error("forward decision without frame end");
	fcs_drop_a: assert property (eof && !rx.fcs_ok |=> !fwd.to_host)
		else $error("frame with bad check sequence forwarded");
	pause_cause_a: assert property ((tx_class_pause & ~$past(tx_class_pause)) != 8'h00 |-> $past(eof && rx.fcs_ok))
		else $error("class paused without a good frame end");
	mng_pause_a: assert property (mng_tx_pause |-> tx_class_pause != 8'h00 || $past(tx_class_pause) != 8'h00)
		else $error("manageability paused with no class paused");
	fmt_timing_a: assert property (fmt_req.req |=> fmt_out.valid)
		else $error("format answer missing");
	fmt_cause_a: assert property (fmt_out.valid |-> $past(fmt_req.req))
		else $error("format answer without request");
	fmt_hold_a: assert property (!fmt_out.valid |-> $stable(fmt_out.timers) && $stable(fmt_out.enable_vec))
		else $error("format fields changed without request");
	cover property (eof ##1 tx_class_pause == 8'hff);
	cover property (fmt_out.valid);
	cover property (fwd.valid && fwd.to_host);
endmodule

bind rx_pause_flow_control rx_pause_asserts u_chk (.clock(clock), .rst_b(rst_b), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .rx(rx), .fwd(fwd), .fmt_req(fmt_req), .fmt_out(fmt_out),
	.tx_class_pause(tx_class_pause), .mng_tx_pause(mng_tx_pause));

// ===== verification/rx_pause_flow_control_tb_top.sv
// Self-checking bench for the receive pause flow control block
module rx_pause_flow_control_tb_top
	import rx_pause_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] LINK = {MAC_CTRL_TYPE, PAUSE_OPCODE};
	localparam logic [31:0] PFC  = 32'h8808_0101;
	logic             clock = 1'b0;
	logic             rst_b = 1'b0;
	apb_req_s         req   = '0;
	apb_rsp_s         rsp;
	rx_byte_s         rx;
	fwd_s             fwd;
	fmt_req_s         fmt   = '0;
	fmt_out_s         fo;
	logic [7:0]       pause;
	logic             mng;
	logic [0:63][7:0] frm   = '0;
	logic             start = 1'b0;
	logic             good  = 1'b1;
	logic             to_host = 1'b0;
	logic             via   = 1'b0;
	logic             err;
	logic [31:0]      rnd   = 32'h0c22;
	logic [31:0]      q;
	logic [31:0]      lo;
	logic [47:0]      sta;
	logic [7:0][15:0] tm;
	int               miscompares = 0;
	int               n_checks = 0;
	int               cyc;

	rx_pause_flow_control DUT (.clock(clock), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp), .rx(rx), .fwd(fwd),
		.fmt_req(fmt), .fmt_out(fo), .tx_class_pause(pause), .mng_tx_pause(mng));
	link_partner_model partner (.clock(clock), .start(start), .frame(frm), .good(good), .rx(rx));

	initial forever #2 clock = ~clock;
	always @(posedge clock) if (fwd.valid) {to_host, via} <= {fwd.to_host, fwd.via_switch};

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Clock cycles per pause quantum, rounded up, for speed code sp
	function automatic int qcyc(input int sp);
		return (QUANTUM_BITS * (sp == 0 ? BIT_PS_10G : sp == 1 ? BIT_PS_2G5 : BIT_PS_1G) + CLOCK_PERIOD_PS - 1)
			/ CLOCK_PERIOD_PS;
	endfunction
	function automatic logic [7:0][15:0] tmr();
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			tmr[i] = rnd[15:0];
		end
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clock);
		req.penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clock);
			if (rsp.pready === 1'b1)
				break;
		end
		q = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		if (k == 20) begin
			miscompares++;
			summarize();
		end
	endtask
	// Fixed wait matches the model's 64-byte frame plus one cycle of answer latency
	task automatic send(input logic [47:0] da, input logic [31:0] to, input logic [15:0] f16,
		input logic [7:0][15:0] t, input logic ok);
		int i;
		for (i = 0; i < 64; i++) begin
			rnd = lfsr(rnd);
			frm[i] = rnd[7:0];
		end
		for (i = 0; i < 6; i++)
			frm[i] = da[47-8*i -: 8];
		{frm[12], frm[13], frm[14], frm[15], frm[16], frm[17]} = {to, f16};
		for (i = 0; i < 8; i++)
			{frm[18+2*i], frm[19+2*i]} = t[i];
		good = ok;
		@(posedge clock);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		repeat (65) @(posedge clock);
		#1;
	endtask

	initial begin
		#200000;
		miscompares++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		apb(1'b1, OFF_TYPE_OPCODE, PFC);
		apb(1'b1, OFF_FLOW_CTRL, 32'h1);
		apb(1'b1, OFF_SPEED, 32'h2);
		lo = lfsr(rnd);
		rnd = lfsr(lo);
		sta = {lo[7:0], lo[15:8], lo[23:16], lo[31:24], rnd[7:0], rnd[15:8]};
		apb(1'b1, OFF_STATION_LO, lo);
		apb(1'b1, OFF_STATION_HI, {16'h0, rnd[15:0]});
		apb(1'b0, OFF_STATION_LO, 32'h0);
		check(q, lo);
		apb(1'b0, 8'h30, 32'h0);
		check({q[30:0], err}, 32'h1);
		for (int v = 0; v < 5; v++) begin
			send(v == 0 ? sta ^ 48'h1 : CTRL_MCAST_ADDR, v == 1 ? 32'h8809_0001 : v == 2 ? 32'h8808_0002 :
				v == 4 ? PFC : LINK, 16'h0005, tmr(), v != 3);
			check(pause, 8'h00);
			if (v >= 2)
				check(to_host, 1'b0);
		end
		apb(1'b0, OFF_XOFF_COUNT, 32'h0);
		check(q, 32'h0);
		send(CTRL_MCAST_ADDR, LINK, 16'h0002, tmr(), 1'b1);
		check(pause, 8'hff);
		check(to_host, 1'b1);
		for (cyc = 0; cyc < 600 && pause !== 8'h00; cyc++)
			@(posedge clock);
		check(cyc >= 120 && cyc <= 384, 1'b1);
		apb(1'b1, OFF_RX_CTRL, 32'h5);
		send(sta, LINK, 16'hffff, tmr(), 1'b1);
		check(pause, 8'hff);
		check(to_host, 1'b0);
		send(CTRL_MCAST_ADDR, LINK, 16'h0000, tmr(), 1'b1);
		check(pause, 8'h00);
		apb(1'b1, OFF_FLOW_CTRL, 32'hff06);
		apb(1'b1, OFF_RX_CLASS_MAP, 32'h9);
		apb(1'b1, OFF_MNG_CLASS_MAP, 32'h1);
		apb(1'b1, OFF_SPEED, 32'h0);
		tm = tmr();
		tm[0] = 16'h0003;
		tm[1] = 16'h00c8;
		send(CTRL_MCAST_ADDR, PFC, 16'h0003, tm, 1'b1);
		check(pause, 8'h02);
		check(mng, 1'b1);
		repeat (100) @(posedge clock);
		#1;
		check(pause, 8'h02);
		send(CTRL_MCAST_ADDR, PFC, 16'h0003, '0, 1'b1);
		check({mng, pause}, 9'h0);
		apb(1'b0, OFF_XOFF_COUNT, 32'h0);
		check(q, 32'h3);
		apb(1'b0, OFF_XON_COUNT, 32'h0);
		check(q, 32'h2);
		apb(1'b1, OFF_TX_CLASS_MAP, 32'h0002_0100);
		for (int v = 0; v < 2; v++) begin
			rnd = lfsr(rnd);
			@(posedge clock);
			fmt <= '{1'b1, 3'd4, 1'b1, rnd[15:0]};
			@(posedge clock);
			fmt.req <= 1'b0;
			#1;
			check({fo.valid, fo.enable_vec}, 9'h124);
			check({fo.timers[2], fo.timers[5]}, {2{rnd[15:0]}});
		end
		// Link frame in priority mode is ignored and falls under the pass-control policy
		apb(1'b1, OFF_RX_CTRL, 32'h6);
		send(CTRL_MCAST_ADDR, LINK, 16'h0005, tmr(), 1'b1);
		check({pause, to_host, via}, 10'h3);
		apb(1'b1, OFF_FLOW_CTRL, 32'h1);
		for (int sp = 0; sp < 2; sp++) begin
			apb(1'b1, OFF_SPEED, 32'(sp));
			send(CTRL_MCAST_ADDR, LINK, 16'h0004, tmr(), 1'b1);
			check({pause, to_host}, 9'h1ff);
			for (cyc = 0; cyc < 600 && pause !== 8'h00; cyc++)
				@(posedge clock);
			check(cyc >= 3 * (qcyc(sp) - 1) && cyc <= 4 * qcyc(sp) + 1, 1'b1);
		end
		apb(1'b0, OFF_XOFF_COUNT, 32'h0);
		check(q, 32'h5);
		summarize();
	end
endmodule
